//--- rtl/pcg_regs.svh
// Register map, field layout and timing constants for clock gating
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PCG_OFF_RUN      12'h000
`define PCG_OFF_RUNSET   12'h004
`define PCG_OFF_RUNCLR   12'h008
`define PCG_OFF_DSLP     12'h00c
`define PCG_OFF_GLOBAL   12'h010
`define PCG_OFF_READY    12'h014
`define PCG_OFF_SLEEP    12'h018

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define PCG_GLOBAL_BIT   0
`define PCG_SLEEP_BIT    0
`define PCG_RUN_RST      32'h0000_0000
`define PCG_DSLP_RST     32'h0000_0000
`define PCG_GLOBAL_RST   1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCG_EN_DELAY     5
`define PCG_CNT_W        3

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define PCG_RESP_OKAY    2'b00
`define PCG_RESP_SLVERR  2'b10

`endif

//--- rtl/pcg_pkg.sv
// Types shared by the peripheral clock gating block
package pcg_pkg;

    // ------------------------------------------------------------------
    // Peripheral count and slice state
    // ------------------------------------------------------------------
    localparam int NUM_PERIPH = 32;

    typedef enum logic [2:0] {
        PCG_OFF     = 3'b001,
        PCG_WAKING  = 3'b010,
        PCG_ON      = 3'b100
    } pcg_slot_e;

    typedef struct packed {
        pcg_slot_e  state;
        logic [2:0] count;
    } pcg_slot_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pcg_wreq_s;

endpackage : pcg_pkg

//--- rtl/pcg_enable_delay.sv
// One peripheral's enable delay sequencer
`timescale 1ns/10ps
`include "pcg_regs.svh"

module pcg_enable_delay #(
    parameter int DELAY = `PCG_EN_DELAY
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Control
    input  wire logic runEnable,
    // Status
    output logic      ready,
    output logic      waking
);

    initial begin
        if (DELAY < 1 || DELAY > 7) begin
            $error("DELAY out of range");
        end
    end

    pcg_pkg::pcg_slot_s st;
    pcg_pkg::pcg_slot_s next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            pcg_pkg::PCG_OFF: begin
                if (runEnable) begin
                    next_st.state = pcg_pkg::PCG_WAKING;
                    next_st.count = 3'(DELAY - 1);
                end
            end
            pcg_pkg::PCG_WAKING: begin
                if (!runEnable) begin
                    next_st.state = pcg_pkg::PCG_OFF;
                end else if (st.count == 3'h0) begin
                    next_st.state = pcg_pkg::PCG_ON;
                end else begin
                    next_st.count = st.count - 3'h1;
                end
            end
            pcg_pkg::PCG_ON: begin
                if (!runEnable) begin
                    next_st.state = pcg_pkg::PCG_OFF;
                end
            end
            default: next_st.state = pcg_pkg::PCG_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st.state <= pcg_pkg::PCG_OFF;
            st.count <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    assign ready  = (st.state == pcg_pkg::PCG_ON);
    assign waking = (st.state == pcg_pkg::PCG_WAKING);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ready_after_five_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(runEnable) ##0 runEnable [*6] |=> ready)
        else $error("Slot not ready five cycles after enable");

    not_early_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(runEnable) |-> !ready ##1 !ready [*5])
        else $error("Slot ready before delay elapsed");

    off_when_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !runEnable |=> !ready)
        else $error("Slot ready while run enable clear");

endmodule : pcg_enable_delay

//--- rtl/pcg_clock_gating.sv
// Peripheral clock gating controller with AXI4-Lite register access
`timescale 1ns/10ps
`include "pcg_regs.svh"

// Overview of operation
// - Gate off deep-sleep-disabled clocks in deep sleep
// - Restore clocks on wake; peripheral state kept
// - Deep-sleep-enabled peripherals keep clock running
// - Global switch off ignores stored deep-sleep bits
// - Run enable clear holds peripheral inactive
// - Run enables reset to disabled
// - Five cycle delay before peripheral enabled
// - Access during enable delay gets bus fault
// - Separate gating control per listed peripheral
// - Global switch off after reset
module pcg_clock_gating #(
    parameter int NPER  = pcg_pkg::NUM_PERIPH,
    parameter int DELAY = `PCG_EN_DELAY
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // AXI4-Lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Processor power state
    input  wire logic              deepSleep,
    // Peripheral bus access monitor
    input  wire logic [4:0]        periphSel,
    input  wire logic              periphAccess,
    output logic                   periphFault,
    // Peripheral gating outputs
    output logic [NPER-1:0]        clockEnable,
    output logic [NPER-1:0]        periphActive
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    initial begin
        if (NPER < 1 || NPER > 32) begin
            $error("NPER must be 1..32");
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    // Bit map: 0 adc, 1-2 can, 3-5 comp, 6-13 ports, 14 hib,
    // 15-16 i2c, 17 pwm, 18 qei, 19-22 timers, 23-25 uart,
    // 26 dma, 27 wdog; upper bits spare
    typedef struct packed {
        logic [NPER-1:0] runEn;
        logic [NPER-1:0] dslpEn;
        logic            globalGate;
        logic            sleepSync1;
        logic            sleepSync2;
        logic            haveAw;
        logic            haveW;
        pcg_pkg::pcg_wreq_s wreq;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic            fault;
    } pcg_state_s;

    pcg_state_s r;
    pcg_state_s next_r;

    logic [NPER-1:0] ready;
    logic [NPER-1:0] waking;

    // ------------------------------------------------------------------
    // Per-peripheral enable delay
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPER; gi++) begin : g_slot
            pcg_enable_delay #(
                .DELAY     (DELAY)
            ) u_delay (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .runEnable (r.runEn[gi]),
                .ready     (ready[gi]),
                .waking    (waking[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] widen(input logic [NPER-1:0] v);
        logic [31:0] w;
        w = 32'h0;
        w[NPER-1:0] = v;
        return w;
    endfunction : widen

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] wd;
        logic [31:0] cur;
        logic        doWrite;
        wd      = 32'h0;
        cur     = 32'h0;
        doWrite = 1'b0;
        next_r  = r;

        // Deep-sleep indication crosses from the power controller
        next_r.sleepSync1 = deepSleep;
        next_r.sleepSync2 = r.sleepSync1;

        // Write channels taken in either order
        if (s_axi_awvalid && !r.haveAw && !r.bvalid) begin
            next_r.haveAw    = 1'b1;
            next_r.wreq.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.haveW && !r.bvalid) begin
            next_r.haveW     = 1'b1;
            next_r.wreq.data = s_axi_wdata;
            next_r.wreq.strb = s_axi_wstrb;
        end

        doWrite = r.haveAw && r.haveW && !r.bvalid;
        if (doWrite) begin
            next_r.haveAw = 1'b0;
            next_r.haveW  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = `PCG_RESP_OKAY;
            wd = merge(32'h0, r.wreq.data, r.wreq.strb);
            case (r.wreq.addr)
                `PCG_OFF_RUN: begin
                    cur = merge(widen(r.runEn), r.wreq.data,
                                r.wreq.strb);
                    next_r.runEn = cur[NPER-1:0];
                end
                `PCG_OFF_RUNSET: begin
                    // Atomic set touches only chosen bits
                    next_r.runEn = r.runEn | wd[NPER-1:0];
                end
                `PCG_OFF_RUNCLR: begin
                    next_r.runEn = r.runEn & ~wd[NPER-1:0];
                end
                `PCG_OFF_DSLP: begin
                    cur = merge(widen(r.dslpEn), r.wreq.data,
                                r.wreq.strb);
                    next_r.dslpEn = cur[NPER-1:0];
                end
                `PCG_OFF_GLOBAL: begin
                    if (r.wreq.strb[0]) begin
                        next_r.globalGate =
                            r.wreq.data[`PCG_GLOBAL_BIT];
                    end
                end
                `PCG_OFF_READY, `PCG_OFF_SLEEP: begin
                    next_r.bresp = `PCG_RESP_OKAY;
                end
                default: next_r.bresp = `PCG_RESP_SLVERR;
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        // Read channel
        if (s_axi_arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = `PCG_RESP_OKAY;
            next_r.rdata  = 32'h0;
            case (s_axi_araddr)
                `PCG_OFF_RUN:    next_r.rdata = widen(r.runEn);
                `PCG_OFF_DSLP:   next_r.rdata = widen(r.dslpEn);
                `PCG_OFF_GLOBAL: next_r.rdata[`PCG_GLOBAL_BIT] =
                                     r.globalGate;
                `PCG_OFF_READY:  next_r.rdata = widen(ready);
                `PCG_OFF_SLEEP:  next_r.rdata[`PCG_SLEEP_BIT] =
                                     r.sleepSync2;
                `PCG_OFF_RUNSET, `PCG_OFF_RUNCLR: begin
                    next_r.rdata = 32'h0;
                end
                default: next_r.rresp = `PCG_RESP_SLVERR;
            endcase
        end else if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // Access to a waking peripheral ends in a fault
        next_r.fault = 1'b0;
        if (periphAccess && int'(periphSel) < NPER) begin
            next_r.fault = waking[periphSel];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r            <= '0;
            r.runEn      <= NPER'(`PCG_RUN_RST);
            r.dslpEn     <= NPER'(`PCG_DSLP_RST);
            r.globalGate <= `PCG_GLOBAL_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Gating outputs
    // ------------------------------------------------------------------
    // Clock stays off until the delay ends; gating only the clock
    // keeps every peripheral register intact across deep sleep
    always_comb begin
        for (int i = 0; i < NPER; i++) begin
            if (r.sleepSync2 && r.globalGate) begin
                clockEnable[i] = ready[i] && r.dslpEn[i];
            end else begin
                clockEnable[i] = ready[i];
            end
        end
    end

    assign periphActive  = ready;
    assign periphFault   = r.fault;
    assign s_axi_awready = !r.haveAw && !r.bvalid;
    assign s_axi_wready  = !r.haveW && !r.bvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    gate_in_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (r.sleepSync2 && r.globalGate) |-> ((clockEnable & ~r.dslpEn) == '0))
        else $error("Clock running for gated peripheral");

    keep_in_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.sleepSync2 |-> ((clockEnable ^ (ready & r.dslpEn)) & r.dslpEn) == '0)
        else $error("Deep-sleep enabled peripheral lost clock");

    restore_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !r.sleepSync2 |-> clockEnable == ready)
        else $error("Clock not restored outside deep sleep");

    switch_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !r.globalGate |-> clockEnable == ready)
        else $error("Deep-sleep bits applied with switch off");

    dslp_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(r.dslpEn) |-> $past(r.haveAw && r.haveW
            && r.wreq.addr == `PCG_OFF_DSLP))
        else $error("Deep-sleep bits changed without write");

    inactive_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (periphActive & ~r.runEn & ~$past(r.runEn)) == '0)
        else $error("Peripheral active while disabled");

    fault_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (periphAccess && int'(periphSel) < NPER && waking[periphSel])
        |=> periphFault)
        else $error("No fault for access during delay");

    set_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(r.haveAw && r.haveW && !r.bvalid
            && r.wreq.addr == `PCG_OFF_RUNSET)
        |-> ((r.runEn ^ $past(r.runEn)) & $past(r.runEn)) == '0)
        else $error("Set write cleared a bit");

endmodule : pcg_clock_gating

//--- test/pcg_core_model.sv
// Processor-side model: power state and peripheral bus accesses
`timescale 1ns/10ps

module pcg_core_model (
    // Clock
    input  wire logic clk_sys,
    // Toward the gating block
    output logic       deepSleep,
    output logic [4:0] periphSel,
    output logic       periphAccess
);
    initial begin
        deepSleep = 1'b0;
        periphSel = 5'h00;
        periphAccess = 1'b0;
    end

    task automatic sleep(input logic lvl);
        @(posedge clk_sys);
        deepSleep <= lvl;
    endtask : sleep

    // Single-cycle access; the index is inverted afterwards, not held
    task automatic touch(input logic [4:0] sel);
        @(posedge clk_sys);
        periphSel <= sel;
        periphAccess <= 1'b1;
        @(posedge clk_sys);
        periphAccess <= 1'b0;
        periphSel <= ~sel;
    endtask : touch
endmodule : pcg_core_model

//--- test/testbench.sv
// Self-checking bench for the peripheral clock gating block
`timescale 1ns/10ps
`include "pcg_regs.svh"

module testbench;
    logic        clk_sys, rst_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        deepSleep, periphAccess, periphFault;
    logic [4:0]  periphSel;
    logic [31:0] clockEnable, periphActive;
    logic [1:0]  resp;
    logic [31:0] rd;
    logic [3:0]  wstrbSel;
    int          errCount, samplesChecked, n;

    pcg_clock_gating uut (.*);
    pcg_core_model core (.clk_sys(clk_sys), .deepSleep(deepSleep),
        .periphSel(periphSel), .periphAccess(periphAccess));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, exp, input string msg);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    // Handshakes are sampled mid-cycle, acted on at the next rising edge
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
        logic awDone, wDone, bSeen;
        int k;
        bSeen = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= wstrbSel;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50 && !bSeen; k++) begin
            @(negedge clk_sys);
            awDone = s_axi_awvalid && s_axi_awready;
            wDone = s_axi_wvalid && s_axi_wready;
            bSeen = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (awDone) s_axi_awvalid <= 1'b0;
            if (wDone) s_axi_wvalid <= 1'b0;
            if (bSeen) s_axi_bready <= 1'b0;
        end
        check(32'(bSeen), 32'h1, "write got no response");
    endtask : axiWr

    task automatic axiRd(input logic [11:0] a);
        logic arDone, rSeen;
        int k;
        rSeen = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50 && !rSeen; k++) begin
            @(negedge clk_sys);
            arDone = s_axi_arvalid && s_axi_arready;
            rSeen = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (arDone) s_axi_arvalid <= 1'b0;
            if (rSeen) s_axi_rready <= 1'b0;
        end
        check(32'(rSeen), 32'h1, "read got no data");
    endtask : axiRd

    task automatic rdCheck(input logic [11:0] a, input logic [31:0] e);
        axiRd(a);
        check(rd, e, "register read value");
        check(32'(resp), 32'(`PCG_RESP_OKAY), "read response");
    endtask : rdCheck

    task automatic settle;
        repeat (3) @(negedge clk_sys);
    endtask : settle

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testReset;
        rdCheck(`PCG_OFF_RUN, `PCG_RUN_RST);
        rdCheck(`PCG_OFF_DSLP, `PCG_DSLP_RST);
        rdCheck(`PCG_OFF_GLOBAL, 32'h0);
        check(periphActive, 32'h0, "active out of reset");
        check(clockEnable, 32'h0, "clock out of reset");
        $display("reset test done");
    endtask : testReset

    task automatic testDelay;
        axiWr(`PCG_OFF_RUNSET, 32'h0000_0008);
        for (n = 0; n < 20; n++) begin
            @(negedge clk_sys);
            if (periphActive[3] === 1'b1) break;
        end
        check(n, `PCG_EN_DELAY, "enable delay length");
        rdCheck(`PCG_OFF_RUN, 32'h0000_0008);
        $display("delay test done");
    endtask : testDelay

    task automatic testFault;
        axiWr(`PCG_OFF_RUNSET, 32'h0000_0020);
        core.touch(5'h05);
        @(negedge clk_sys);
        check(32'(periphFault), 32'h1, "fault while waking");
        // Software waits out the delay before touching again
        repeat (8) @(negedge clk_sys);
        core.touch(5'h05);
        @(negedge clk_sys);
        check(32'(periphFault), 32'h0, "fault once enabled");
        $display("fault test done");
    endtask : testFault

    task automatic testSleep;
        axiWr(`PCG_OFF_DSLP, 32'h0000_0020);
        axiWr(`PCG_OFF_GLOBAL, 32'h0000_0001);
        core.sleep(1'b1);
        settle();
        check(32'(clockEnable[3]), 32'h0, "gated in deep sleep");
        check(32'(clockEnable[5]), 32'h1, "kept in deep sleep");
        rdCheck(`PCG_OFF_SLEEP, 32'h1);
        core.sleep(1'b0);
        settle();
        check(32'(clockEnable[3]), 32'h1, "clock back on wake");
        check(32'(periphActive[3]), 32'h1, "active on wake");
        axiWr(`PCG_OFF_GLOBAL, 32'h0);
        core.sleep(1'b1);
        settle();
        check(32'(clockEnable[3]), 32'h1, "switch off ignored");
        rdCheck(`PCG_OFF_DSLP, 32'h0000_0020);
        core.sleep(1'b0);
        settle();
        $display("sleep test done");
    endtask : testSleep

    task automatic testClear;
        axiWr(`PCG_OFF_RUNCLR, 32'h0000_0008);
        @(negedge clk_sys);
        check(32'(periphActive[3]), 32'h0, "cleared inactive");
        check(32'(clockEnable[3]), 32'h0, "cleared gated");
        check(32'(periphActive[5]), 32'h1, "neighbour kept");
        axiRd(12'h0fc);
        check(32'(resp), 32'(`PCG_RESP_SLVERR), "unmapped read");
        check(rd, 32'h0, "unmapped read data");
        axiWr(12'h0fc, 32'h1);
        check(32'(resp), 32'(`PCG_RESP_SLVERR), "unmapped write");
        $display("clear test done");
    endtask : testClear

    task automatic testAll;
        axiWr(`PCG_OFF_RUN, 32'h0fff_ffff);
        repeat (8) @(negedge clk_sys);
        check(periphActive, 32'h0fff_ffff, "all active");
        check(clockEnable, 32'h0fff_ffff, "all clocked");
        rdCheck(`PCG_OFF_READY, 32'h0fff_ffff);
        // Strobe only the low byte lane; the other three lanes keep their deep-sleep bits
        wstrbSel = 4'h1;
        axiWr(`PCG_OFF_DSLP, 32'hffff_ffff);
        wstrbSel = 4'hf;
        rdCheck(`PCG_OFF_DSLP, 32'h0000_00ff);
        $display("all peripherals test done");
    endtask : testAll

    initial begin
        errCount = 0;
        samplesChecked = 0;
        wstrbSel = 4'hf;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        testReset();
        testDelay();
        testFault();
        testSleep();
        testClear();
        testAll();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        summarize();
    end
endmodule : testbench
